// >>> core/mie_consts.vh
/*
 Constants for the instruction execute block: register offsets,
 opcode and response encodings, flag positions, reset values, timing.
 Assumes inclusion by bare name from the core design files.
*/
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH

`define MIE_REG_INSTR 8'h00
`define MIE_REG_STATUS 8'h04
`define MIE_REG_PC 8'h08
`define MIE_RESP_OKAY 2'h0
`define MIE_RESP_SLVERR 2'h2

`define MIE_OP_NOP 4'h0
`define MIE_OP_ADD 4'h1
`define MIE_OP_ADDI 4'h2
`define MIE_OP_SUB 4'h3
`define MIE_OP_SUBI 4'h4
`define MIE_OP_LOGIC 4'h5
`define MIE_OP_LOGICI 4'h6
`define MIE_OP_INV 4'h7
`define MIE_OP_INCDEC 4'h8
`define MIE_OP_ROT 4'h9
`define MIE_OP_BCD 4'hA
`define MIE_OP_BITOP 4'hB
`define MIE_OP_SKIP 4'hC
`define MIE_OP_SKIPBIT 4'hD
`define MIE_OP_MOV 4'hE
`define MIE_OP_BRANCH 4'hF

`define MIE_F_Z 0
`define MIE_F_C 1
`define MIE_F_AC 2
`define MIE_F_OV 3
`define MIE_F_SC 4
`define MIE_F_CZ 5

`define MIE_ACC_RST 8'h00
`define MIE_PC_RST 8'h00
`define MIE_FLAG_RST 6'h00
`define MIE_PCL_ADDR 8'h06
`define MIE_BCD_LIMIT 4'h9

`define MIE_CLK_PER_ICYC 3'h4
`define MIE_LAST_PHASE 2'h3

`endif

// >>> core/mie_ram.v
/*
 Small synchronous memory with registered read data, one write port.
 Assumes one clock; read data appear the cycle after the address.
*/
`timescale 1ns/10ps
`default_nettype none
module mie_ram #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire ref_clk,
    input wire reset,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    // array itself has no reset, only the read register
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata <= {DW{1'b0}};
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // mie_ram
`default_nettype wire

// >>> core/mie_alu.v
/*
 Combinational arithmetic and logic unit for the execute block.
 Assumes the caller picks the operand (memory byte or immediate).
*/
`timescale 1ns/10ps
`default_nettype none
`include "mie_consts.vh"
module mie_alu (
    input wire [3:0] op,
    input wire [2:0] sub,
    input wire [7:0] acc,
    input wire [7:0] opnd,
    input wire [5:0] flg_in,
    output reg [7:0] res,
    output reg [5:0] flg_out
);
    reg [8:0] wide;
    reg [4:0] half;
    reg [7:0] b;
    reg cin;
    reg is_sub;

    always @* begin
        wide = 9'h000;
        half = 5'h00;
        b = opnd;
        cin = 1'b0;
        is_sub = (op == `MIE_OP_SUB) || (op == `MIE_OP_SUBI);
        res = opnd;
        flg_out = flg_in;
        case (op)
            `MIE_OP_ADD, `MIE_OP_ADDI, `MIE_OP_SUB, `MIE_OP_SUBI: begin
                // subtract as a + ~b + 1; carry set means no borrow
                b = is_sub ? ~opnd : opnd;
                cin = sub[0] ? flg_in[`MIE_F_C] : is_sub;
                wide = {1'b0, acc} + {1'b0, b} + {8'h00, cin};
                half = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                res = wide[7:0];
                flg_out[`MIE_F_Z] = (res == 8'h00);
                flg_out[`MIE_F_C] = wide[8];
                flg_out[`MIE_F_AC] = half[4];
                flg_out[`MIE_F_OV] = (acc[7] == b[7]) && (res[7] != acc[7]);
                flg_out[`MIE_F_SC] = flg_out[`MIE_F_OV] ^ res[7];
                // compare zero chains through carry-in form
                if (is_sub) begin
                    flg_out[`MIE_F_CZ] = sub[0] ? ((res == 8'h00) & flg_in[`MIE_F_CZ])
                                                : (res == 8'h00);
                end
            end
            `MIE_OP_LOGIC, `MIE_OP_LOGICI: begin
                case (sub[1:0])
                    2'h0: res = acc & opnd;
                    2'h1: res = acc | opnd;
                    default: res = acc ^ opnd;
                endcase
                flg_out[`MIE_F_Z] = (res == 8'h00);
            end
            `MIE_OP_INV: begin
                res = ~opnd;
                flg_out[`MIE_F_Z] = (res == 8'h00);
            end
            `MIE_OP_INCDEC: begin
                res = sub[0] ? opnd - 8'h01 : opnd + 8'h01;
                flg_out[`MIE_F_Z] = (res == 8'h00);
            end
            `MIE_OP_ROT: begin
                if (sub[1]) begin
                    res = sub[0] ? {opnd[6:0], flg_in[`MIE_F_C]}
                                 : {flg_in[`MIE_F_C], opnd[7:1]};
                    flg_out[`MIE_F_C] = sub[0] ? opnd[7] : opnd[0];
                end else begin
                    res = sub[0] ? {opnd[6:0], opnd[7]} : {opnd[0], opnd[7:1]};
                end
            end
            `MIE_OP_BCD: begin
                wide = {1'b0, acc} + (((acc[3:0] > `MIE_BCD_LIMIT) || flg_in[`MIE_F_AC])
                                      ? 9'h006 : 9'h000);
                if ((wide[8:4] > {1'b0, `MIE_BCD_LIMIT}) || flg_in[`MIE_F_C]) begin
                    wide = wide + 9'h060;
                end
                res = wide[7:0];
                flg_out[`MIE_F_C] = wide[8] | flg_in[`MIE_F_C];
            end
            default: res = opnd;
        endcase
    end
endmodule // mie_alu
`default_nettype wire

// >>> core/mie_core.v
/*
 Instruction execute core for an 8-bit controller, reached over AXI4-Lite.
 Software writes one instruction word at a time; the core runs it over
 four clocks per instruction cycle against its own sector 0 data memory.
 Assumes a single clock and an AXI4-Lite master that keeps the protocol.
*/
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "mie_consts.vh"
module mie_core (
    input wire ref_clk,
    input wire reset,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // 0 instr, 1 status, 2 pc, 3 unmapped
    function [1:0] reg_sel;
        input [7:0] a;
        begin
            case (a)
                `MIE_REG_INSTR: reg_sel = 2'h0;
                `MIE_REG_STATUS: reg_sel = 2'h1;
                `MIE_REG_PC: reg_sel = 2'h2;
                default: reg_sel = 2'h3;
            endcase
        end
    endfunction

    function [7:0] bit_mask;
        input [2:0] idx;
        begin
            bit_mask = 8'h01 << idx;
        end
    endfunction

    reg aw_full_q;
    reg [7:0] aw_addr_q;
    reg w_full_q;
    reg [15:0] w_data_q;
    reg [1:0] w_strb_q;
    reg busy_q;
    reg second_q;
    reg [1:0] phase_q;
    reg [15:0] ir_q;
    reg [7:0] acc_q;
    reg [5:0] flags_q;
    reg [7:0] pc_q;
    reg [2:0] sp_q;
    reg skip_pend_q;
    reg [7:0] opnd_q;
    reg [7:0] stk_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire instr_hit = (reg_sel(aw_addr_q) == 2'h0);
    wire strb_ok = (w_strb_q == 2'h3);
    // instruction writes wait while the core is busy: that is the back-pressure
    wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid & ~(instr_hit & busy_q);
    wire issue = wr_go & instr_hit & strb_ok;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

    wire [3:0] op = ir_q[15:12];
    wire dm = ir_q[11];
    wire [2:0] sub = ir_q[10:8];
    wire [7:0] fld = ir_q[7:0];
    wire last_phase = busy_q & (phase_q == `MIE_LAST_PHASE);
    wire commit = last_phase & ~second_q;

    wire [7:0] ram_rdata;
    wire [7:0] stk_rdata;
    wire [7:0] alu_res;
    wire [5:0] alu_flg;
    wire imm_op = (op == `MIE_OP_ADDI) || (op == `MIE_OP_SUBI) || (op == `MIE_OP_LOGICI);
    wire [3:0] alu_op = (op == `MIE_OP_SKIP) ? `MIE_OP_INCDEC : op;
    wire [7:0] alu_b = imm_op ? fld : opnd_q;

    reg [7:0] res_d;
    reg [7:0] pc_d;
    reg acc_wr;
    reg mem_wr;
    reg flg_wr;
    reg two_d;
    reg skip_d;
    reg push_d;
    reg pop_d;

    wire pcl_hit = mem_wr & (fld == `MIE_PCL_ADDR);
    wire ram_we = commit & mem_wr & ~pcl_hit;
    wire [7:0] pc_inc = pc_q + 8'h01;

    // immediate taken straight from the instruction field
    mie_alu u_alu (
        .op(alu_op),
        .sub(sub),
        .acc(acc_q),
        .opnd(alu_b),
        .flg_in(flags_q),
        .res(alu_res),
        .flg_out(alu_flg)
    );

    // 8-bit operand address covers sector 0 only
    mie_ram #(.AW(8), .DW(8)) u_dmem (
        .ref_clk(ref_clk),
        .reset(reset),
        .we(ram_we),
        .waddr(fld),
        .wdata(res_d),
        .raddr(fld),
        .rdata(ram_rdata)
    );

    // stack wraps after eight nested calls
    mie_ram #(.AW(3), .DW(8)) u_stack (
        .ref_clk(ref_clk),
        .reset(reset),
        .we(commit & push_d),
        .waddr(sp_q),
        .wdata(pc_inc),
        .raddr(sp_q - 3'h1),
        .rdata(stk_rdata)
    );

    always @* begin
        res_d = alu_res;
        pc_d = pc_inc;
        acc_wr = 1'b0;
        mem_wr = 1'b0;
        flg_wr = 1'b0;
        two_d = 1'b0;
        skip_d = 1'b0;
        push_d = 1'b0;
        pop_d = 1'b0;
        case (op)
            `MIE_OP_ADD, `MIE_OP_SUB, `MIE_OP_LOGIC, `MIE_OP_INV, `MIE_OP_INCDEC,
            `MIE_OP_ROT: begin
                mem_wr = dm;
                acc_wr = ~dm;
                flg_wr = 1'b1;
            end
            `MIE_OP_ADDI, `MIE_OP_SUBI, `MIE_OP_LOGICI: begin
                acc_wr = 1'b1;
                flg_wr = 1'b1;
            end
            `MIE_OP_BCD: begin
                mem_wr = 1'b1;
                flg_wr = 1'b1;
            end
            `MIE_OP_BITOP: begin
                res_d = dm ? (opnd_q | bit_mask(sub)) : (opnd_q & ~bit_mask(sub));
                mem_wr = 1'b1;
            end
            `MIE_OP_SKIP: begin
                case (sub[1:0])
                    2'h0: skip_d = (opnd_q == 8'h00);
                    2'h1: skip_d = (opnd_q != 8'h00);
                    default: begin
                        skip_d = (alu_res == 8'h00);
                        mem_wr = dm;
                        acc_wr = ~dm;
                    end
                endcase
            end
            `MIE_OP_SKIPBIT: begin
                skip_d = dm ? ((opnd_q & bit_mask(sub)) != 8'h00)
                            : ((opnd_q & bit_mask(sub)) == 8'h00);
            end
            `MIE_OP_MOV: begin
                case (sub[1:0])
                    2'h0: begin
                        res_d = fld;
                        acc_wr = 1'b1;
                    end
                    2'h1: begin
                        res_d = opnd_q;
                        acc_wr = 1'b1;
                    end
                    default: begin
                        res_d = acc_q;
                        mem_wr = 1'b1;
                    end
                endcase
            end
            `MIE_OP_BRANCH: begin
                two_d = 1'b1;
                case (sub[1:0])
                    2'h0: pc_d = fld;
                    2'h1: begin
                        push_d = 1'b1;
                        pc_d = fld;
                    end
                    2'h2: begin
                        pop_d = 1'b1;
                        pc_d = stk_q;
                    end
                    default: two_d = 1'b0;
                endcase
            end
            default: res_d = alu_res;
        endcase
        // low counter byte written through memory
        if (mem_wr && (fld == `MIE_PCL_ADDR)) begin
            pc_d = res_d;
            two_d = 1'b1;
        end
        // taken skip jumps over the next word
        if (skip_d) begin
            pc_d = pc_q + 8'h02;
            two_d = 1'b1;
        end
    end

    // bus slave, write side
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q <= 1'b0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MIE_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata[15:0];
                w_strb_q <= s_axi_wstrb[1:0];
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
            s_axi_awready <= ~(aw_take | (aw_full_q & ~wr_go));
            s_axi_wready <= ~(w_take | (w_full_q & ~wr_go));
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= issue ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // bus slave, read side
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MIE_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_take) begin
                s_axi_rresp <= `MIE_RESP_OKAY;
                case (reg_sel(s_axi_araddr))
                    2'h0: s_axi_rdata <= {16'h0000, ir_q};
                    2'h1: s_axi_rdata <= {14'h0000, skip_pend_q, busy_q, 2'h0, flags_q,
                                          acc_q};
                    2'h2: s_axi_rdata <= {21'h000000, sp_q, pc_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `MIE_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // sequencer and architectural state
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
            second_q <= 1'b0;
            phase_q <= 2'h0;
            ir_q <= 16'h0000;
            acc_q <= `MIE_ACC_RST;
            flags_q <= `MIE_FLAG_RST;
            pc_q <= `MIE_PC_RST;
            sp_q <= 3'h0;
            skip_pend_q <= 1'b0;
            opnd_q <= 8'h00;
            stk_q <= 8'h00;
        end else begin
            if (issue) begin
                // a skipped word is consumed without running
                if (skip_pend_q) begin
                    skip_pend_q <= 1'b0;
                end else begin
                    busy_q <= 1'b1;
                    ir_q <= w_data_q;
                    phase_q <= 2'h0;
                    second_q <= 1'b0;
                end
            end else if (busy_q) begin
                phase_q <= phase_q + 2'h1;
                if (phase_q == 2'h1) begin
                    opnd_q <= ram_rdata;
                    stk_q <= stk_rdata;
                end
                if (last_phase) begin
                    if (commit && two_d) begin
                        second_q <= 1'b1;
                    end else begin
                        busy_q <= 1'b0;
                        second_q <= 1'b0;
                    end
                end
                if (commit) begin
                    pc_q <= pc_d;
                    skip_pend_q <= skip_d;
                    if (acc_wr) begin
                        acc_q <= res_d;
                    end
                    if (flg_wr) begin
                        flags_q <= alu_flg;
                    end
                    if (push_d) begin
                        sp_q <= sp_q + 3'h1;
                    end else if (pop_d) begin
                        sp_q <= sp_q - 3'h1;
                    end
                end
            end
        end
    end
endmodule // mie_core
`default_nettype wire

// >>> bench/mie_core_sva.sv
/* assertions on the AXI4-Lite ports of mie_core.
 assumes a bind from the bench top and mie_consts.vh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "mie_consts.vh"
module mie_core_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    property p_rst_rdy; $fell(reset) |-> ##1 (s_axi_awready && s_axi_arready); endproperty
    a_rst_rdy: assert property (p_rst_rdy) else $error("ready missing after reset");
    property p_aw_take; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_take: assert property (p_aw_take) else $error("awready stayed high");
    property p_b_lat; wr_go && s_axi_awaddr != `MIE_REG_INSTR |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_b_err; wr_go && s_axi_awaddr == `MIE_REG_STATUS |-> ##2
        s_axi_bresp == `MIE_RESP_SLVERR; endproperty
    a_b_err: assert property (p_b_err) else $error("status write not refused");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_ar_low; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_low: assert property (p_ar_low) else $error("arready high with read pending");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_err; s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0C |=>
        s_axi_rresp == `MIE_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
    c_wr_ok: cover property (s_axi_bvalid && s_axi_bresp == `MIE_RESP_OKAY);
    c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == `MIE_RESP_SLVERR);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // mie_core_sva
`default_nettype wire

// >>> bench/mie_core_tb.sv
/* self-checking bench for mie_core: instructions issued over AXI4-Lite.
 assumes mie_consts.vh on the include path and mie_core_sva compiled. */
`timescale 1ns/10ps
`default_nettype none
`include "mie_consts.vh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e); end end
module mie_core_tb;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] sreg, q;
    logic [1:0] r;
    logic [5:0] f;
    int num_errors = 0, checks_done = 0, cyc = 0, b_cyc = 0, d1, d2;
    mie_core dut_u (.*);
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    function automatic logic [15:0] ins(input logic [3:0] o, input logic d,
        input logic [2:0] s, input logic [7:0] m);
        return {o, d, s, m};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // the wait ends when bvalid is seen; there is no timeout here but the watchdog
        while (s_axi_bvalid !== 1'h1) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end
        b_cyc = cyc;
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, er, "write response");
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (s_axi_rvalid !== 1'h1) begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // issue one instruction, then poll until idle; sreg keeps the last status
    task automatic ex(input logic [15:0] i);
        wr(`MIE_REG_INSTR, i, `MIE_RESP_OKAY);
        sreg = 32'hFFFFFFFF;
        while (sreg[16] !== 1'h0) begin
            rd(`MIE_REG_STATUS, sreg, r);
        end
    endtask
    task automatic setm(input logic [7:0] m, input logic [7:0] v);
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, v));
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h2, m));
    endtask
    task automatic pair(input logic [15:0] i, output int d);
        int t;
        wr(`MIE_REG_INSTR, i, `MIE_RESP_OKAY);
        t = b_cyc;
        ex(16'h0000);
        d = b_cyc - t;
    endtask
    task automatic t_reset;
        rd(`MIE_REG_STATUS, q, r);
        `CHK(q, 32'h0, "status after reset");
        rd(`MIE_REG_PC, q, r);
        `CHK(q, 32'h0, "pc after reset");
        rd(8'h0C, q, r);
        `CHK(r, `MIE_RESP_SLVERR, "unmapped read");
        wr(`MIE_REG_STATUS, 16'h1234, `MIE_RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_arith;
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, 8'hF0));
        ex(ins(`MIE_OP_ADDI, 1'h0, 3'h0, 8'h20));
        `CHK(sreg[13:0], 14'h0210, "add carry out");
        ex(ins(`MIE_OP_ADDI, 1'h0, 3'h1, 8'h6F));
        `CHK(sreg[13:0], 14'h0C80, "add carry in");
        ex(ins(`MIE_OP_SUBI, 1'h0, 3'h0, 8'h80));
        `CHK(sreg[13:0] & 14'h3BFF, 14'h2300, "sub zero");
        ex(ins(`MIE_OP_SUBI, 1'h0, 3'h1, 8'h01));
        `CHK(sreg[13:0] & 14'h3BFF, 14'h10FF, "sub borrow");
        setm(8'h30, 8'h01);
        ex(ins(`MIE_OP_ADD, 1'h1, 3'h0, 8'h30));
        // sign flag was set before, so a stale flag set shows here
        `CHK(sreg[13:0], 14'h0001, "add flags, acc kept");
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h1, 8'h30));
        `CHK(sreg[7:0], 8'h02, "add to memory");
        $display("test arith done");
    endtask
    task automatic t_logic;
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, 8'hFF));
        f = sreg[13:8];
        for (int k = 0; k < 3; k++) begin
            ex(ins(`MIE_OP_LOGICI, 1'h0, k[2:0], k == 0 ? 8'h00 : 8'h5A));
            `CHK(sreg[13:0], {f[5:1], k != 1, k == 1 ? 8'h5A : 8'h00}, "logic");
        end
        setm(8'h31, 8'h0F);
        ex(ins(`MIE_OP_INV, 1'h0, 3'h0, 8'h31));
        `CHK(sreg[13:0], {f[5:1], 1'h0, 8'hF0}, "invert to acc");
        ex(ins(`MIE_OP_INV, 1'h1, 3'h0, 8'h31));
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h1, 8'h31));
        `CHK(sreg[7:0], 8'hF0, "invert in place");
        setm(8'h32, 8'hFF);
        ex(ins(`MIE_OP_INCDEC, 1'h1, 3'h0, 8'h32));
        `CHK(sreg[13:0], {f[5:1], 1'h1, 8'hFF}, "increment memory");
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, 8'h00));
        ex(ins(`MIE_OP_INCDEC, 1'h0, 3'h1, 8'h32));
        `CHK(sreg[13:0], {f[5:1], 1'h0, 8'hFF}, "decrement to acc");
        $display("test logic done");
    endtask
    task automatic t_rot;
        setm(8'h33, 8'h81);
        f = sreg[13:8];
        ex(ins(`MIE_OP_ROT, 1'h0, 3'h1, 8'h33));
        `CHK(sreg[13:0], {f, 8'h03}, "rotate left");
        ex(ins(`MIE_OP_ROT, 1'h0, 3'h0, 8'h33));
        `CHK(sreg[13:0], {f, 8'hC0}, "rotate right");
        ex(ins(`MIE_OP_ROT, 1'h0, 3'h2, 8'h33));
        `CHK(sreg[13:0], {f[5:2], 1'h1, f[0], 8'h40}, "ring right");
        // two steps so that the carry taken in shows in the result
        repeat (2) ex(ins(`MIE_OP_ROT, 1'h1, 3'h3, 8'h33));
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h1, 8'h33));
        `CHK(sreg[13:0], {f[5:2], 1'h0, f[0], 8'h07}, "ring left");
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, 8'h09));
        ex(ins(`MIE_OP_ADDI, 1'h0, 3'h0, 8'h09));
        f = sreg[13:8];
        ex(ins(`MIE_OP_BCD, 1'h0, 3'h0, 8'h34));
        `CHK(sreg[13:0], {f, 8'h12}, "adjust flags");
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h1, 8'h34));
        `CHK(sreg[7:0], 8'h18, "adjust result");
        $display("test rotate done");
    endtask
    task automatic t_bits;
        setm(8'h35, 8'h00);
        for (int i = 0; i < 8; i++) ex(ins(`MIE_OP_BITOP, 1'h1, i[2:0], 8'h35));
        for (int i = 1; i < 8; i += 2) ex(ins(`MIE_OP_BITOP, 1'h0, i[2:0], 8'h35));
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h1, 8'h35));
        `CHK(sreg[7:0], 8'h55, "bit set and clear");
        $display("test bits done");
    endtask
    task automatic t_flow;
        pair(16'h0000, d1);
        // one instruction cycle plus the single edge on which the next write acts and answers
        `CHK(d1, `MIE_CLK_PER_ICYC + 1, "single cycle length");
        pair(ins(`MIE_OP_BRANCH, 1'h0, 3'h0, 8'h40), d2);
        `CHK(d2, d1 + 4, "jump length");
        pair(ins(`MIE_OP_BRANCH, 1'h0, 3'h1, 8'h80), d2);
        `CHK(d2, d1 + 4, "call length");
        ex(ins(`MIE_OP_BRANCH, 1'h0, 3'h2, 8'h00));
        rd(`MIE_REG_PC, q, r);
        `CHK(q[7:0], 8'h42, "return address");
        setm(8'h36, 8'h00);
        pair(ins(`MIE_OP_SKIP, 1'h0, 3'h0, 8'h36), d2);
        `CHK(d2, d1 + 4, "taken skip length");
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, 8'h11));
        ex(ins(`MIE_OP_SKIP, 1'h0, 3'h1, 8'h36));
        ex(ins(`MIE_OP_SKIPBIT, 1'h0, 3'h3, 8'h36));
        ex(ins(`MIE_OP_MOV, 1'h0, 3'h0, 8'h77));
        `CHK(sreg[7:0], 8'h11, "skipped move");
        rd(`MIE_REG_PC, q, r);
        `CHK(q[7:0], 8'h4A, "pc after skips");
        pair(ins(`MIE_OP_MOV, 1'h0, 3'h2, `MIE_PCL_ADDR), d2);
        `CHK(d2, d1 + 4, "counter byte write length");
        rd(`MIE_REG_PC, q, r);
        `CHK(q[7:0], 8'h12, "counter byte write");
        $display("test flow done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'h0;
        repeat (2) @(posedge ref_clk);
        t_reset;
        t_arith;
        t_logic;
        t_rot;
        t_bits;
        t_flow;
        give_verdict;
    end
    // generous bound; the full run needs under a thousand clocks
    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule // mie_core_tb
bind mie_core mie_core_sva chk_u (.*);
`default_nettype wire
